// file: hdl/fcc_pkg.sv
// package: offsets, field layouts and constants for the common control group
package fcc_pkg;
   // ************************************************************
   // register offsets on the parallel control port
   // ************************************************************
   localparam logic [7:0] FCC_OFS_A_LINE = 8'h0a; // line interface control
   localparam logic [7:0] FCC_OFS_A_RX = 8'h1e; // framer a receive control
   localparam logic [7:0] FCC_OFS_B_TX = 8'hb9; // framer b transmit control
   localparam logic [7:0] FCC_OFS_B_RX = 8'hbe; // framer b receive control

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int FCC_BIT_JAPAN = 7; // crc6 algorithm select, tx and rx
   localparam int FCC_BIT_ACCUM = 6; // accumulation mode select
   localparam int FCC_BIT_MANUAL = 5; // manual counter update
   localparam int FCC_BIT_LINE_IFACE_RESET = 7; // line interface reset
   localparam int FCC_BIT_RLB = 6; // remote loopback
   localparam int FCC_BIT_AIS_HI = 5; // ais channels 13..24
   localparam int FCC_BIT_AIS_LO = 4; // ais channels 1..12
   localparam int FCC_BIT_CLDIS = 3; // carrier-loss pin disable
   localparam int FCC_BIT_LBO3 = 0; // build-out select bit 3
   localparam int FCC_CHAN_MSB = 4; // channel select msb
   localparam logic [7:0] FCC_TX_WMASK = 8'h9f; // writable transmit bits
   localparam logic [7:0] FCC_LINE_WMASK = 8'hf9; // writable line bits

   // ************************************************************
   // reset values and frame layout
   // ************************************************************
   localparam logic [7:0] FCC_RST_REG = 8'h00; // all control bits clear
   localparam logic [4:0] FCC_HALF_CHAN = 5'h0c; // last lower-half channel
   localparam logic [4:0] FCC_LAST_CHAN = 5'h18; // channel 24
   localparam logic [7:0] FCC_ALL_ONES = 8'hff; // ais slot content

   // ************************************************************
   // bus signals
   // ************************************************************
   typedef struct packed
   {
      logic wr; // one-cycle write strobe
      logic [7:0] addr; // register address
      logic [7:0] wdata; // write data
   } fcc_wr_t;

   typedef struct packed
   {
      logic slot_start; // first cycle of a channel slot
      logic [4:0] chan; // channel number 1..24
      logic [7:0] data; // slot data
   } fcc_slot_t;
endpackage : fcc_pkg

// file: hdl/fcc_ctrl.sv
// common control registers 5 to 7 of a dual framer with line interface
`timescale 1ns/1ps

// Contract
// - framer b tx bit7 picks japanese crc6; framer a tx select held low
// - rx bit7 picks japanese crc6 check
// - framer b tx bits4..0 choose monitored channel; framer a tx select held at 0
// - rx bits4..0 choose monitored channel
// - accumulation mode: auto interval or manual; framer b auto interval held low, so use_b never rises
// - manual rise loads counts next cycle
// - reset bit rise resets line interface
// - per-half ais enables replace data
// - disable forces carrier-loss pin low
// - remote loopback retransmits receive line
module fcc_ctrl
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // register write port
   input wire fcc_pkg::fcc_wr_t i_wr,
   // register read port
   input wire logic [7:0] i_rd_addr,
   output logic [7:0] o_rd_data,
   // framer a control register 3 auto interval bit
   input wire logic i_a_auto_interval,
   // transmit and receive slot streams, framer a
   input wire fcc_pkg::fcc_slot_t i_a_tx_slot,
   input wire fcc_pkg::fcc_slot_t i_a_rx_slot,
   // framer b transmit and receive slot streams
   input wire fcc_pkg::fcc_slot_t i_b_tx_slot,
   input wire fcc_pkg::fcc_slot_t i_b_rx_slot,
   // line interface signals
   input wire logic [1:0] i_line_rx, // received pos/neg
   input wire logic [1:0] i_fmt_tx, // formatter pos/neg
   input wire logic i_carrier_loss, // true carrier loss
   // line and transmit outputs
   output logic [1:0] o_line_tx,
   output logic o_carrier_loss_pin,
   output logic o_carrier_loss_status,
   output logic [7:0] o_a_tx_data, // formatter slot data after ais
   // monitor registers
   output logic [7:0] o_a_tx_channel_monitor_reg,
   output logic [7:0] o_a_rx_channel_monitor_reg,
   output logic [7:0] o_b_tx_channel_monitor_reg,
   output logic [7:0] o_b_rx_channel_monitor_reg,
   // control outputs
   output logic o_a_tx_japan_crc_sel,
   output logic o_a_rx_japan_crc_sel,
   output logic o_b_tx_japan_crc_sel,
   output logic o_b_rx_japan_crc_sel,
   output logic o_a_counter_load, // one-cycle load of error counts
   output logic o_b_counter_load,
   output logic o_a_use_auto_interval,
   output logic o_b_use_auto_interval,
   output logic o_line_iface_reset, // one-cycle internal reset
   output logic o_buildout_sel_bit3
);
   // ************************************************************
   // register storage
   // ************************************************************
   logic [7:0] line_ctrl; // line interface control
   logic [7:0] a_rx_ctrl; // framer a receive control
   logic [7:0] b_tx_ctrl; // framer b transmit control
   logic [7:0] b_rx_ctrl; // framer b receive control
   logic [7:0] a_tx_ctrl; // framer a transmit control, held cleared (no input)
   logic b_auto_interval; // framer b auto interval (held low, no input)

   // ************************************************************
   // decode
   // ************************************************************
   wire wr_line = i_wr.wr && (i_wr.addr == fcc_pkg::FCC_OFS_A_LINE);
   wire wr_a_rx = i_wr.wr && (i_wr.addr == fcc_pkg::FCC_OFS_A_RX);
   wire wr_b_tx = i_wr.wr && (i_wr.addr == fcc_pkg::FCC_OFS_B_TX);
   wire wr_b_rx = i_wr.wr && (i_wr.addr == fcc_pkg::FCC_OFS_B_RX);
   // unassigned bits are stored as zero whatever the host writes
   wire [7:0] line_wval = i_wr.wdata & fcc_pkg::FCC_LINE_WMASK;
   wire [7:0] b_tx_wval = i_wr.wdata & fcc_pkg::FCC_TX_WMASK;

   // edge detect on the strobe bits, compared against stored value
   wire a_manual_rise = wr_a_rx && i_wr.wdata[fcc_pkg::FCC_BIT_MANUAL]
      && !a_rx_ctrl[fcc_pkg::FCC_BIT_MANUAL]
      && a_rx_ctrl[fcc_pkg::FCC_BIT_ACCUM];
   wire b_manual_rise = wr_b_rx && i_wr.wdata[fcc_pkg::FCC_BIT_MANUAL]
      && !b_rx_ctrl[fcc_pkg::FCC_BIT_MANUAL]
      && b_rx_ctrl[fcc_pkg::FCC_BIT_ACCUM];
   // holding the bit high gives no further reset pulses
   wire line_iface_reset_rise = wr_line && i_wr.wdata[fcc_pkg::FCC_BIT_LINE_IFACE_RESET]
      && !line_ctrl[fcc_pkg::FCC_BIT_LINE_IFACE_RESET];

   // read mux; unmapped addresses read zero
   wire [7:0] next_rd_data =
      (i_rd_addr == fcc_pkg::FCC_OFS_A_LINE) ? line_ctrl :
      (i_rd_addr == fcc_pkg::FCC_OFS_A_RX) ? a_rx_ctrl :
      (i_rd_addr == fcc_pkg::FCC_OFS_B_TX) ? b_tx_ctrl :
      (i_rd_addr == fcc_pkg::FCC_OFS_B_RX) ? b_rx_ctrl : 8'h00;

   // ************************************************************
   // ais decision for the framer a transmit slot
   // ************************************************************
   wire a_in_lower = i_a_tx_slot.chan <= fcc_pkg::FCC_HALF_CHAN;
   wire a_ais = a_in_lower ? line_ctrl[fcc_pkg::FCC_BIT_AIS_LO]
      : line_ctrl[fcc_pkg::FCC_BIT_AIS_HI];
   wire [7:0] next_a_tx_data = a_ais ? fcc_pkg::FCC_ALL_ONES
      : i_a_tx_slot.data;

   // remote loopback picks received line data for transmit
   wire [1:0] next_line_tx = line_ctrl[fcc_pkg::FCC_BIT_RLB]
      ? i_line_rx : i_fmt_tx;

   // ************************************************************
   // monitor capture: slot match on the selected channel
   // ************************************************************
   function automatic logic chan_hit(input fcc_pkg::fcc_slot_t s,
      input logic [4:0] sel);
      chan_hit = s.slot_start && (s.chan == sel);
   endfunction : chan_hit

   wire a_tx_hit = chan_hit(i_a_tx_slot, a_tx_ctrl[4:0]);
   wire a_rx_hit = chan_hit(i_a_rx_slot, a_rx_ctrl[4:0]);
   wire b_tx_hit = chan_hit(i_b_tx_slot, b_tx_ctrl[4:0]);
   wire b_rx_hit = chan_hit(i_b_rx_slot, b_rx_ctrl[4:0]);

   // ************************************************************
   // register writes
   // ************************************************************
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         line_ctrl <= fcc_pkg::FCC_RST_REG;
         a_rx_ctrl <= fcc_pkg::FCC_RST_REG;
         b_tx_ctrl <= fcc_pkg::FCC_RST_REG;
         b_rx_ctrl <= fcc_pkg::FCC_RST_REG;
         a_tx_ctrl <= fcc_pkg::FCC_RST_REG;
         b_auto_interval <= 1'b0;
      end
      else
      begin
         // single-port write, one register per cycle
         if (wr_line)
            line_ctrl <= line_wval;
         if (wr_a_rx)
            a_rx_ctrl <= i_wr.wdata;
         if (wr_b_tx)
            b_tx_ctrl <= b_tx_wval;
         if (wr_b_rx)
            b_rx_ctrl <= i_wr.wdata;
         // framer a transmit register lives elsewhere; stays cleared
         a_tx_ctrl <= fcc_pkg::FCC_RST_REG;
         b_auto_interval <= 1'b0;
      end
   end

   // ************************************************************
   // strobes and read data
   // ************************************************************
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_a_counter_load <= 1'b0;
         o_b_counter_load <= 1'b0;
         o_line_iface_reset <= 1'b0;
         o_rd_data <= 8'h00;
      end
      else
      begin
         // load lands on the cycle after the write
         o_a_counter_load <= a_manual_rise;
         o_b_counter_load <= b_manual_rise;
         o_line_iface_reset <= line_iface_reset_rise;
         o_rd_data <= next_rd_data;
      end
   end

   // ************************************************************
   // monitor registers, refreshed once per frame
   // ************************************************************
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_a_tx_channel_monitor_reg <= 8'h00;
         o_a_rx_channel_monitor_reg <= 8'h00;
         o_b_tx_channel_monitor_reg <= 8'h00;
         o_b_rx_channel_monitor_reg <= 8'h00;
      end
      else
      begin
         // each channel number occurs once per frame
         if (a_tx_hit)
            o_a_tx_channel_monitor_reg <= i_a_tx_slot.data;
         if (a_rx_hit)
            o_a_rx_channel_monitor_reg <= i_a_rx_slot.data;
         if (b_tx_hit)
            o_b_tx_channel_monitor_reg <= i_b_tx_slot.data;
         if (b_rx_hit)
            o_b_rx_channel_monitor_reg <= i_b_rx_slot.data;
      end
   end

   // ************************************************************
   // registered control and line outputs
   // ************************************************************
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_a_tx_japan_crc_sel <= 1'b0;
         o_a_rx_japan_crc_sel <= 1'b0;
         o_b_tx_japan_crc_sel <= 1'b0;
         o_b_rx_japan_crc_sel <= 1'b0;
         o_a_use_auto_interval <= 1'b0;
         o_b_use_auto_interval <= 1'b0;
         o_line_tx <= 2'b00;
         o_carrier_loss_pin <= 1'b0;
         o_carrier_loss_status <= 1'b0;
         o_a_tx_data <= 8'h00;
         o_buildout_sel_bit3 <= 1'b0;
      end
      else
      begin
         o_a_tx_japan_crc_sel <= a_tx_ctrl[fcc_pkg::FCC_BIT_JAPAN];
         o_b_tx_japan_crc_sel <= b_tx_ctrl[fcc_pkg::FCC_BIT_JAPAN];
         o_a_rx_japan_crc_sel <= a_rx_ctrl[fcc_pkg::FCC_BIT_JAPAN];
         o_b_rx_japan_crc_sel <= b_rx_ctrl[fcc_pkg::FCC_BIT_JAPAN];
         // auto interval governs only while accumulation mode is 0
         o_a_use_auto_interval <= !a_rx_ctrl[fcc_pkg::FCC_BIT_ACCUM]
            && i_a_auto_interval;
         o_b_use_auto_interval <= !b_rx_ctrl[fcc_pkg::FCC_BIT_ACCUM]
            && b_auto_interval;
         o_line_tx <= next_line_tx;
         // pin forced low; status keeps the true condition
         o_carrier_loss_pin <= i_carrier_loss
            && !line_ctrl[fcc_pkg::FCC_BIT_CLDIS];
         o_carrier_loss_status <= i_carrier_loss;
         o_a_tx_data <= next_a_tx_data;
         o_buildout_sel_bit3 <= line_ctrl[fcc_pkg::FCC_BIT_LBO3];
      end
   end
endmodule : fcc_ctrl

// file: tb/fcc_ctrl_asserts.sv
// checker: concurrent assertions on the common control ports
`timescale 1ns/1ps
module fcc_ctrl_chk
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // watched inputs
   input wire fcc_pkg::fcc_wr_t i_wr,
   input wire logic i_carrier_loss,
   input wire fcc_pkg::fcc_slot_t i_a_tx_slot,
   input wire fcc_pkg::fcc_slot_t i_a_rx_slot,
   // watched outputs
   input wire logic o_carrier_loss_pin,
   input wire logic [7:0] o_a_tx_data,
   input wire logic [7:0] o_a_rx_channel_monitor_reg,
   input wire logic o_a_tx_japan_crc_sel,
   input wire logic o_b_tx_japan_crc_sel,
   input wire logic o_a_counter_load,
   input wire logic o_line_iface_reset
);
   // one clock domain, so one clocking and one disable
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // a load needs a write with bit5 set one edge before
   load_cause_a: assert property (
      o_a_counter_load |-> $past(i_wr.wr) &&
      $past(i_wr.addr) == fcc_pkg::FCC_OFS_A_RX &&
      $past(i_wr.wdata[5]))
      else $error("counter load without a raising write");
   load_single_a: assert property (
      o_a_counter_load |=> !o_a_counter_load)
      else $error("counter load longer than one cycle");
   reset_cause_a: assert property (
      o_line_iface_reset |-> $past(i_wr.wr) &&
      $past(i_wr.addr) == fcc_pkg::FCC_OFS_A_LINE &&
      $past(i_wr.wdata[7]))
      else $error("line reset without a raising write");
   // a reset pulse lasts one cycle, never high on two edges in a row
   reset_single_a: assert property (
      o_line_iface_reset |=> !o_line_iface_reset)
      else $error("line reset pulse repeated");
   pin_cause_a: assert property (
      o_carrier_loss_pin |-> $past(i_carrier_loss))
      else $error("carrier-loss pin high without carrier loss");
   // slot data either passes or is replaced by all ones
   ais_data_a: assert property (
      o_a_tx_data == 8'hff || o_a_tx_data == $past(i_a_tx_slot.data))
      else $error("transmit slot data corrupted");
   mon_source_a: assert property (
      $changed(o_a_rx_channel_monitor_reg) |->
      $past(i_a_rx_slot.slot_start) &&
      o_a_rx_channel_monitor_reg == $past(i_a_rx_slot.data))
      else $error("monitor changed outside a slot start");
   tx_crc_zero_a: assert property (
      !o_a_tx_japan_crc_sel)
      else $error("framer a transmit crc select not held low");
   // stored on the write edge, registered out one edge later
   tx_crc_follow_a: assert property (
      i_wr.wr && i_wr.addr == fcc_pkg::FCC_OFS_B_TX |->
      ##2 o_b_tx_japan_crc_sel == $past(i_wr.wdata[7], 2))
      else $error("framer b transmit crc select not following its write");
endmodule : fcc_ctrl_chk

bind fcc_ctrl fcc_ctrl_chk chk (.i_clock, .i_rst_n, .i_wr, .i_carrier_loss,
   .i_a_tx_slot, .i_a_rx_slot, .o_carrier_loss_pin, .o_a_tx_data,
   .o_a_rx_channel_monitor_reg, .o_a_tx_japan_crc_sel,
   .o_b_tx_japan_crc_sel, .o_a_counter_load, .o_line_iface_reset);

// file: tb/test_framer_common_control_5_to_7.sv
// testbench: register accesses and datapath checks for the control group
`timescale 1ns/1ps
module test_framer_common_control_5_to_7;
   // stimulus, all driven from time zero
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   fcc_pkg::fcc_wr_t i_wr = '0;
   logic [7:0] i_rd_addr = 8'h00;
   logic i_a_auto_interval = 1'b1;
   fcc_pkg::fcc_slot_t slot [4] = '{default: '0}; // a tx, a rx, b tx, b rx
   logic [1:0] i_line_rx = 2'b10;
   logic [1:0] i_fmt_tx = 2'b01;
   logic i_carrier_loss = 1'b0;
   // observed outputs
   logic [7:0] rd_data, a_tx_data;
   logic [7:0] mon [4];
   logic [1:0] line_tx;
   logic cl_pin, cl_stat, load_a, load_b, use_a, use_b, li_rst, bo3;
   logic [3:0] crc; // a tx, a rx, b tx, b rx
   logic [2:0] pulse; // line reset, load a, load b seen after a write edge
   logic [7:0] ofs [4] = '{8'h0a, 8'h1e, 8'hb9, 8'hbe};
   logic [7:0] wm [4] = '{8'hf9, 8'hff, 8'h9f, 8'hff}; // unassigned bits read 0
   int err_count = 0;
   int n_tests = 0;

   fcc_ctrl uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_wr(i_wr),
      .i_rd_addr(i_rd_addr), .o_rd_data(rd_data),
      .i_a_auto_interval(i_a_auto_interval), .i_a_tx_slot(slot[0]),
      .i_a_rx_slot(slot[1]), .i_b_tx_slot(slot[2]), .i_b_rx_slot(slot[3]),
      .i_line_rx(i_line_rx), .i_fmt_tx(i_fmt_tx),
      .i_carrier_loss(i_carrier_loss), .o_line_tx(line_tx),
      .o_carrier_loss_pin(cl_pin), .o_carrier_loss_status(cl_stat),
      .o_a_tx_data(a_tx_data), .o_a_tx_channel_monitor_reg(mon[0]),
      .o_a_rx_channel_monitor_reg(mon[1]),
      .o_b_tx_channel_monitor_reg(mon[2]),
      .o_b_rx_channel_monitor_reg(mon[3]), .o_a_tx_japan_crc_sel(crc[0]),
      .o_a_rx_japan_crc_sel(crc[1]), .o_b_tx_japan_crc_sel(crc[2]),
      .o_b_rx_japan_crc_sel(crc[3]), .o_a_counter_load(load_a),
      .o_b_counter_load(load_b), .o_a_use_auto_interval(use_a),
      .o_b_use_auto_interval(use_b), .o_line_iface_reset(li_rst),
      .o_buildout_sel_bit3(bo3));

   // ************************************************************
   // clock, access tasks and verdict
   // ************************************************************
   initial
   begin
      forever #2 i_clock = ~i_clock;
   end

   // compare one value, case equality so unknowns fail
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one-cycle write strobe, then an idle edge so strobes never abut;
   // the one-cycle pulses only stand until that idle edge, so catch them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_wr = '{1'b1, a, d};
      @(posedge i_clock);
      #1 i_wr.wr = 1'b0;
      pulse = {li_rst, load_a, load_b};
      @(posedge i_clock);
      #1;
   endtask : wr

   // read data is registered, so look one edge after the address
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      i_rd_addr = a;
      @(posedge i_clock);
      #1 chk(rd_data, exp);
   endtask : rd

   // single slot start on stream k
   task automatic put(input int k, input logic [4:0] c, input logic [7:0] d);
      slot[k] = '{1'b1, c, d};
      @(posedge i_clock);
      #1 slot[k].slot_start = 1'b0;
   endtask : put

   task automatic finish_test;
      if (err_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // ************************************************************
   // test sequence
   // ************************************************************
   initial
   begin
      repeat (2) @(posedge i_clock);
      #1 i_rst_n = 1'b1;
      // reset value, writable-mask write, readback; both mode bits at once
      foreach (ofs[i])
      begin
         rd(ofs[i], 8'h00);
         wr(ofs[i], wm[i]);
         chk(pulse[2], 8'(i == 0));
         chk(pulse[1], 8'h00);
         rd(ofs[i], wm[i]);
      end
      rd(8'h55, 8'h00);
      chk(crc, 8'h0e);
      chk(crc[2], 8'h01);
      chk(bo3, 8'h01);
      chk(use_a, 8'h00);
      chk(line_tx, 8'h02);
      i_carrier_loss = 1'b1;
      repeat (2) @(posedge i_clock);
      #1 chk(cl_pin, 8'h00);
      chk(cl_stat, 8'h01);
      // single half enabled at a time, boundary channels 12 and 13
      wr(8'h0a, 8'h10);
      chk(cl_pin, 8'h01);
      chk(line_tx, 8'h01);
      chk(bo3, 8'h00);
      put(0, 5'h0c, 8'h3c);
      chk(a_tx_data, 8'hff);
      chk(mon[0], 8'h00);
      put(0, 5'h0d, 8'h3c);
      chk(a_tx_data, 8'h3c);
      wr(8'h0a, 8'h20);
      put(0, 5'h0c, 8'h3c);
      chk(a_tx_data, 8'h3c);
      put(0, 5'h0d, 8'h3c);
      chk(a_tx_data, 8'hff);
      // cleared then set again gives a fresh line reset
      wr(8'h0a, 8'h80);
      chk(pulse[2], 8'h01);
      // bit left at one: no further reset
      wr(8'h0a, 8'h80);
      chk(pulse[2], 8'h00);
      // manual update rises with accumulation bit already stored
      wr(8'h1e, 8'h47);
      wr(8'h1e, 8'h67);
      chk(pulse[1], 8'h01);
      put(1, 5'h07, 8'ha5);
      chk(mon[1], 8'ha5);
      put(1, 5'h08, 8'h11);
      chk(mon[1], 8'ha5);
      wr(8'h1e, 8'h07);
      chk(use_a, 8'h01);
      // auto interval bit drops; the governed output follows it
      i_a_auto_interval = 1'b0;
      @(posedge i_clock);
      #1 chk(use_a, 8'h00);
      wr(8'h1e, 8'h27);
      chk(pulse[1], 8'h00);
      // framer b monitors, top channel and bottom channel
      wr(8'hb9, 8'h18);
      put(2, 5'h18, 8'h5a);
      chk(mon[2], 8'h5a);
      wr(8'hbe, 8'h01);
      put(3, 5'h01, 8'hc3);
      chk(mon[3], 8'hc3);
      // framer b manual update, accumulation bit stored first
      wr(8'hbe, 8'h41);
      chk(use_b, 8'h00);
      wr(8'hbe, 8'h61);
      chk(pulse[0], 8'h01);
      finish_test();
   end

   // watchdog well beyond the under sixty cycles the sequence needs
   initial
   begin
      #20000;
      err_count++;
      finish_test();
   end
endmodule : test_framer_common_control_5_to_7
